//--- fsg_pkg.sv
// Package: constants and types for the flash protection host controller
package fsg_pkg;
  // Software register offsets (word index on the plain port)
  localparam logic [3:0] FSG_REG_CTRL = 4'h0;
  localparam logic [3:0] FSG_REG_ADDR = 4'h1;
  localparam logic [3:0] FSG_REG_DATA = 4'h2;
  localparam logic [3:0] FSG_REG_CMD = 4'h3;
  localparam logic [3:0] FSG_REG_STAT = 4'h4;
  localparam logic [3:0] FSG_REG_RDATA = 4'h5;
  localparam logic [3:0] FSG_REG_PROT = 4'h6;
  // Control register fields
  localparam int FSG_CTRL_WP_BIT = 0;
  localparam int FSG_CTRL_ACC_BIT = 1;
  localparam int FSG_CTRL_RSTID_BIT = 2;
  localparam int FSG_CTRL_RST_BIT = 3;
  localparam int FSG_CTRL_A9ID_BIT = 4;
  localparam int FSG_CTRL_PGMEQ_BIT = 5;
  localparam logic [7:0] FSG_CTRL_RESET = 8'h01;
  // Command codes written to FSG_REG_CMD
  localparam logic [2:0] FSG_CMD_WRITE = 3'h1;
  localparam logic [2:0] FSG_CMD_READ = 3'h2;
  localparam logic [2:0] FSG_CMD_UNLOCK_WRITE = 3'h3;
  localparam logic [2:0] FSG_CMD_PROT_QUERY = 3'h4;
  // Unlock cycle addresses and data
  localparam logic [19:0] FSG_UNLOCK_ADDR1 = 20'h00555;
  localparam logic [19:0] FSG_UNLOCK_ADDR2 = 20'h002AA;
  localparam logic [15:0] FSG_UNLOCK_DATA1 = 16'h00AA;
  localparam logic [15:0] FSG_UNLOCK_DATA2 = 16'h0055;
  // Protection query: A6=0 A1=1 A0=0 with sector on A19..A12
  localparam logic [19:0] FSG_QUERY_LOW = 20'h00002;
  localparam logic [7:0] FSG_PROT_YES = 8'h01;
  localparam logic [7:0] FSG_PROT_NO = 8'h00;
  // Strobe timing: 100 MHz clock
  localparam int FSG_CLK_NS = 10;
  localparam int FSG_GLITCH_NS = 5;
  localparam int FSG_STROBE_NS = 60;
  localparam int FSG_SETUP_NS = 20;
  localparam int FSG_STROBE_CYC = (FSG_STROBE_NS + FSG_CLK_NS - 1) / FSG_CLK_NS;
  localparam int FSG_SETUP_CYC = (FSG_SETUP_NS + FSG_CLK_NS - 1) / FSG_CLK_NS;
  localparam int FSG_GLITCH_CYC = (FSG_GLITCH_NS + FSG_CLK_NS - 1) / FSG_CLK_NS;
  typedef enum logic [2:0] {
    FSG_ST_IDLE = 3'b000,
    FSG_ST_SETUP = 3'b001,
    FSG_ST_PULSE = 3'b010,
    FSG_ST_HOLD = 3'b011,
    FSG_ST_NEXT = 3'b100
  } fsg_state_t;
endpackage

//--- fsg_bus_if.sv
// Interface: one bus-cycle request and answer between sequencer and pin engine
`timescale 1ns/10ps
interface fsg_bus_if;
  logic req;
  logic wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic busy;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, wr, addr, wdata, input busy, done, rdata);
  modport eng (input req, wr, addr, wdata, output busy, done, rdata);
endinterface

//--- fsg_pin_engine.sv
// Pin engine: drives one flash bus cycle on chip select and strobes
`timescale 1ns/10ps
module fsg_pin_engine
  import fsg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  fsg_bus_if.eng bus,
  input wire logic [15:0] dq_sync,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [19:0] a_out,
  output logic [15:0] dq_out,
  output logic dq_oe
);
  typedef struct packed {
    fsg_state_t st;
    logic [7:0] cnt;
    logic wr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [19:0] a;
    logic [15:0] d;
    logic dq_oe;
    logic done;
    logic [15:0] rdata;
  } fsg_eng_t;
  fsg_eng_t s_ff, nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      FSG_ST_IDLE:
      begin
        if (bus.req)
        begin
          nxt_s.st = FSG_ST_SETUP;
          nxt_s.wr = bus.wr;
          nxt_s.a = bus.addr;
          nxt_s.d = bus.wdata;
          nxt_s.cnt = 8'(FSG_SETUP_CYC);
          // Output strobe stays high on writes; low only on reads
          nxt_s.oe_n = 1'b1;
          nxt_s.dq_oe = bus.wr;
        end
      end
      FSG_ST_SETUP:
      begin
        if (s_ff.cnt > 8'h01)
          nxt_s.cnt = s_ff.cnt - 8'h01;
        else
        begin
          nxt_s.st = FSG_ST_PULSE;
          nxt_s.ce_n = 1'b0;
          nxt_s.we_n = !s_ff.wr;
          nxt_s.oe_n = s_ff.wr;
          // Pulse far longer than the glitch filter
          nxt_s.cnt = 8'(FSG_STROBE_CYC > FSG_GLITCH_CYC ? FSG_STROBE_CYC : FSG_GLITCH_CYC + 1);
        end
      end
      FSG_ST_PULSE:
      begin
        if (s_ff.cnt > 8'h01)
          nxt_s.cnt = s_ff.cnt - 8'h01;
        else
        begin
          nxt_s.st = FSG_ST_HOLD;
          nxt_s.rdata = dq_sync;
          nxt_s.we_n = 1'b1;
          nxt_s.oe_n = 1'b1;
          nxt_s.cnt = 8'(FSG_SETUP_CYC);
        end
      end
      FSG_ST_HOLD:
      begin
        nxt_s.ce_n = 1'b1;
        if (s_ff.cnt > 8'h01)
          nxt_s.cnt = s_ff.cnt - 8'h01;
        else
        begin
          nxt_s.st = FSG_ST_IDLE;
          nxt_s.dq_oe = 1'b0;
          nxt_s.done = 1'b1;
        end
      end
      default:
        nxt_s.st = FSG_ST_IDLE;
    endcase
    if (reset)
    begin
      nxt_s = '0;
      nxt_s.st = FSG_ST_IDLE;
      nxt_s.ce_n = 1'b1;
      nxt_s.we_n = 1'b1;
      nxt_s.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_ff <= nxt_s;
  end

  assign bus.busy = (s_ff.st != FSG_ST_IDLE);
  assign bus.done = s_ff.done;
  assign bus.rdata = s_ff.rdata;
  assign ce_n = s_ff.ce_n;
  assign we_n = s_ff.we_n;
  assign oe_n = s_ff.oe_n;
  assign a_out = s_ff.a;
  assign dq_out = s_ff.d;
  assign dq_oe = s_ff.dq_oe;
endmodule

//--- fsg_host_ctrl.sv
// Host controller: drives a protected parallel NOR flash through its pins
`timescale 1ns/10ps
module fsg_host_ctrl
  import fsg_pkg::*;
#(
  parameter bit TOP_BOOT = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic supply_ok,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_reset_n,
  output logic reset_id_high_voltage,
  output logic address_bit_nine_id_high_voltage,
  output logic boot_guard_accel_pin,
  output logic program_accelerate
);
  // Sector group index on address bits 19..12
  function automatic logic [5:0] fsg_group(input logic [7:0] hi, input logic top);
    if (top)
    begin
      if (hi[7:3] == 5'h1F)
        return 6'h20 + {3'h0, hi[2:0]};
      else if (hi[7:5] == 3'h0)
        return (hi[4:3] == 2'h0) ? 6'h00 : 6'h01;
      else if (hi[7:3] >= 5'h1C)
        return 6'h08;
      else
        return {3'h0, hi[7:5]} + 6'h01;
    end
    else
      // Bottom-boot top sector stands alone
      return (hi[7:3] == 5'h1F) ? 6'h3F : {1'b0, hi[7:3]};
  endfunction

  // Outermost two boot sectors
  function automatic logic fsg_outer(input logic [7:0] hi, input logic top);
    return top ? (hi[7:1] == 7'h7F) : (hi[7:1] == 7'h00);
  endfunction

  typedef struct packed {
    logic [7:0] ctrl;
    logic [19:0] addr;
    logic [15:0] data;
    logic [2:0] cmd;
    logic [1:0] step;
    logic busy;
    logic err;
    logic [15:0] rdata;
    logic [7:0] prot;
    logic req;
    logic wr;
    logic [19:0] baddr;
    logic [15:0] bdata;
    logic [31:0] rd;
    logic s1;
    logic s2;
    logic [15:0] dq1;
    logic [15:0] dq2;
  } fsg_top_t;
  fsg_top_t s_ff, nxt_s;

  fsg_bus_if bus ();

  fsg_pin_engine u_eng (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus(bus.eng),
    .dq_sync(s_ff.dq2),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_n(flash_oe_n),
    .a_out(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe)
  );

  assign bus.req = s_ff.req;
  assign bus.wr = s_ff.wr;
  assign bus.addr = s_ff.baddr;
  assign bus.wdata = s_ff.bdata;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.req = 1'b0;
    nxt_s.s1 = supply_ok;
    nxt_s.s2 = s_ff.s1;
    nxt_s.dq1 = flash_dq_in;
    nxt_s.dq2 = s_ff.dq1;
    nxt_s.rd = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        FSG_REG_CTRL: nxt_s.rd = {24'h0, s_ff.ctrl};
        FSG_REG_ADDR: nxt_s.rd = {12'h0, s_ff.addr};
        FSG_REG_DATA: nxt_s.rd = {16'h0, s_ff.data};
        FSG_REG_STAT: nxt_s.rd = {29'h0, s_ff.s2, s_ff.err, s_ff.busy};
        FSG_REG_RDATA: nxt_s.rd = {16'h0, s_ff.rdata};
        FSG_REG_PROT: nxt_s.rd = {24'h0, s_ff.prot};
        default: nxt_s.rd = 32'h0;
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        FSG_REG_CTRL: nxt_s.ctrl = reg_wdata[7:0];
        FSG_REG_ADDR: nxt_s.addr = reg_wdata[19:0];
        FSG_REG_DATA: nxt_s.data = reg_wdata[15:0];
        FSG_REG_CMD:
        begin
          if (!s_ff.busy)
          begin
            // Writes refused while supply below lockout
            if (!s_ff.s2 && reg_wdata[2:0] != FSG_CMD_READ && reg_wdata[2:0] != FSG_CMD_PROT_QUERY)
              nxt_s.err = 1'b1;
            else
            begin
              nxt_s.cmd = reg_wdata[2:0];
              nxt_s.busy = 1'b1;
              nxt_s.err = 1'b0;
              nxt_s.step = 2'h0;
            end
          end
        end
        default: ;
      endcase
    end
    // Clamp the value being written so the level never shows for a cycle
    if (!nxt_s.ctrl[FSG_CTRL_PGMEQ_BIT])
      nxt_s.ctrl[FSG_CTRL_A9ID_BIT] = 1'b0;
    if (s_ff.busy && !bus.busy && !s_ff.req)
    begin
      case (s_ff.cmd)
        // Unlock writes precede the program word
        FSG_CMD_UNLOCK_WRITE:
        begin
          nxt_s.req = 1'b1;
          nxt_s.wr = 1'b1;
          nxt_s.step = s_ff.step + 2'h1;
          case (s_ff.step)
            2'h0:
            begin
              nxt_s.baddr = FSG_UNLOCK_ADDR1;
              nxt_s.bdata = FSG_UNLOCK_DATA1;
            end
            2'h1:
            begin
              nxt_s.baddr = FSG_UNLOCK_ADDR2;
              nxt_s.bdata = FSG_UNLOCK_DATA2;
            end
            2'h2:
            begin
              nxt_s.baddr = s_ff.addr;
              nxt_s.bdata = s_ff.data;
            end
            default:
            begin
              nxt_s.req = 1'b0;
              nxt_s.busy = 1'b0;
            end
          endcase
        end
        FSG_CMD_WRITE, FSG_CMD_READ, FSG_CMD_PROT_QUERY:
        begin
          if (s_ff.step == 2'h0)
          begin
            nxt_s.req = 1'b1;
            nxt_s.wr = (s_ff.cmd == FSG_CMD_WRITE);
            nxt_s.bdata = s_ff.data;
            // Query: sector on high bits, answer on low byte
            nxt_s.baddr = (s_ff.cmd == FSG_CMD_PROT_QUERY) ?
              {s_ff.addr[19:12], FSG_QUERY_LOW[11:0]} : s_ff.addr;
            nxt_s.step = 2'h1;
          end
          else if (bus.done)
          begin
            nxt_s.busy = 1'b0;
            nxt_s.rdata = bus.rdata;
            if (s_ff.cmd == FSG_CMD_PROT_QUERY)
              nxt_s.prot = (bus.rdata[7:0] == FSG_PROT_YES) ? FSG_PROT_YES : FSG_PROT_NO;
          end
        end
        default: nxt_s.busy = 1'b0;
      endcase
      // Lockout may arrive mid-sequence; drop the remaining writes
      if (nxt_s.req && nxt_s.wr && !s_ff.s2)
      begin
        nxt_s.req = 1'b0;
        nxt_s.busy = 1'b0;
        nxt_s.err = 1'b1;
      end
    end
    if (reset)
    begin
      nxt_s = '0;
      nxt_s.ctrl = FSG_CTRL_RESET;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_ff <= nxt_s;
  end

  assign reg_rdata = s_ff.rd;
  // Reset pin left released; lockout is enforced by refusing writes instead
  assign flash_reset_n = 1'b1;
  assign reset_id_high_voltage = s_ff.ctrl[FSG_CTRL_RSTID_BIT];
  assign address_bit_nine_id_high_voltage = s_ff.ctrl[FSG_CTRL_A9ID_BIT];
  assign boot_guard_accel_pin = s_ff.ctrl[FSG_CTRL_WP_BIT];
  // Acceleration off after reset; only software raises it
  assign program_accelerate = s_ff.ctrl[FSG_CTRL_ACC_BIT];
endmodule

//--- fsg_host_ctrl_monitor.sv
// Checker: flash pin protocol of the host controller
`timescale 1ns/10ps
module fsg_host_ctrl_monitor
  import fsg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic supply_ok,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [19:0] flash_addr,
  input wire logic flash_dq_oe,
  input wire logic flash_reset_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence we_low;
    (!flash_we_n) [*6];
  endsequence
  sequence we_release;
    flash_we_n && !flash_ce_n;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  AST_WE_QUAL: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without chip select or with output strobe");
  AST_WE_PULSE: assert property ($fell(flash_we_n) |-> we_low ##1 we_release)
    else $error("write pulse length wrong");
  AST_WE_DATA: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data not driven during write");
  AST_SUPPLY: assert property ($fell(flash_we_n) |-> $past(supply_ok, 6))
    else $error("write started under supply lockout");
  AST_RESET_PIN: assert property (flash_reset_n)
    else $error("hardware reset pin asserted");
  AST_OE_READ: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("read cycle qualifiers wrong");
  AST_ADDR_HOLD: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved within a cycle");
endmodule

bind fsg_host_ctrl fsg_host_ctrl_monitor u_mon (.clk_sys, .reset, .reg_rd, .reg_rdata,
  .supply_ok, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_oe, .flash_reset_n);

//--- fsg_flash_model.sv
// Behavioural top-boot flash: unlock decode, group protection, query
`timescale 1ns/10ps
module fsg_flash_model
  import fsg_pkg::*;
(
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic supply_ok,
  input wire logic reset_id_high_voltage,
  input wire logic address_bit_nine_id_high_voltage,
  input wire logic boot_guard_accel_pin,
  input wire logic program_accelerate,
  output logic [15:0] flash_dq_in
);
  logic [16:0] prot_ff = 17'h0;
  logic [15:0] mem [int];
  logic [15:0] dq_v;
  int seq_st = 0;
  int upd = 0;
  bit auto_mode = 0;
  realtime t_fall = 0;
  function automatic int grp(input logic [7:0] a);
    if (a[7:3] == 5'h1F) return 9 + a[2:0];
    if (a[7:5] == 3'h0) return int'(a[4:3] != 2'h0);
    return a[7:5] + 1;
  endfunction
  function automatic bit locked(input logic [19:0] a);
    if (program_accelerate) return 0;
    if (a[19:13] == 7'h7F && !boot_guard_accel_pin) return 1;
    return prot_ff[grp(a[19:12])] && !reset_id_high_voltage;
  endfunction
  function automatic logic [15:0] arr(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic logic [15:0] rd(input logic [19:0] a);
    if ((auto_mode || address_bit_nine_id_high_voltage) && a[6:0] == FSG_QUERY_LOW[6:0])
      return {8'h00, prot_ff[grp(a[19:12])] ? FSG_PROT_YES : FSG_PROT_NO};
    return arr(a);
  endfunction
  task automatic take(input logic [19:0] a, input logic [15:0] d);
    if (seq_st == 3 && !locked(a)) mem[a] = arr(a) & d;
    if (d == 16'h00F0) auto_mode = 0;
    if (seq_st == 2 && a == FSG_UNLOCK_ADDR1 && d == 16'h0090) auto_mode = 1;
    seq_st = (seq_st == 0 && a == FSG_UNLOCK_ADDR1 && d == FSG_UNLOCK_DATA1) ? 1 :
      (seq_st == 1 && a == FSG_UNLOCK_ADDR2 && d == FSG_UNLOCK_DATA2) ? 2 :
      (seq_st == 2 && a == FSG_UNLOCK_ADDR1 && d == 16'h00A0) ? 3 : 0;
    upd++;
  endtask
  always @(negedge flash_we_n) t_fall = $realtime;
  always @(negedge supply_ok)
  begin
    seq_st = 0;
    auto_mode = 0;
  end
  // Glitch filter keeps short strobe noise out of the unlock decoder
  always @(posedge flash_we_n)
    if (!flash_ce_n && flash_oe_n && supply_ok && $realtime - t_fall >= 5.0)
      take(flash_addr, flash_dq_out);
  always @(flash_ce_n or flash_oe_n or flash_addr or upd or prot_ff or auto_mode or
    address_bit_nine_id_high_voltage)
    dq_v = rd(flash_addr);
  // Released bus shows the inverse so a stale value never passes
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? dq_v : ~dq_v;
endmodule

//--- fsg_host_ctrl_tb.sv
// Testbench: register-driven program, protection and query sequences
`timescale 1ns/10ps
module fsg_host_ctrl_tb;
  import fsg_pkg::*;
  logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, supply_ok = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, got;
  logic flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, flash_reset_n;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic reset_id_high_voltage, address_bit_nine_id_high_voltage;
  logic boot_guard_accel_pin, program_accelerate;
  int n_mismatch = 0, n_tests = 0;
  fsg_host_ctrl #(.TOP_BOOT(1'b1)) dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .supply_ok, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr,
    .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_reset_n, .reset_id_high_voltage,
    .address_bit_nine_id_high_voltage, .boot_guard_accel_pin, .program_accelerate);
  fsg_flash_model mdl (.flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_out,
    .supply_ok, .reset_id_high_voltage, .address_bit_nine_id_high_voltage,
    .boot_guard_accel_pin, .program_accelerate, .flash_dq_in);
  initial forever #5 clk_sys = ~clk_sys;
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Busy poll is bounded so a stuck engine shows as a mismatch
  task run(input logic [2:0] c);
    wr(FSG_REG_CMD, {29'h0, c});
    repeat (2) @(posedge clk_sys);
    got = 32'h1;
    for (int i = 0; i < 60 && got[0] !== 1'b0; i++) rd(FSG_REG_STAT, got);
    chk("busy", 32'h0, {31'h0, got[0]});
  endtask
  task prog(input logic [19:0] a, input logic [15:0] d);
    wr(FSG_REG_ADDR, {12'h0, FSG_UNLOCK_ADDR1});
    wr(FSG_REG_DATA, 32'h00A0);
    run(FSG_CMD_UNLOCK_WRITE);
    wr(FSG_REG_ADDR, {12'h0, a});
    wr(FSG_REG_DATA, {16'h0, d});
    run(FSG_CMD_WRITE);
  endtask
  task fetch(input logic [19:0] a, input logic [15:0] exp, input string what);
    wr(FSG_REG_ADDR, {12'h0, a});
    run(FSG_CMD_READ);
    rd(FSG_REG_RDATA, got);
    chk(what, {16'h0, exp}, got);
  endtask
  // In-system query: autoselect entry before, reset command after
  task query(input logic [19:0] a, input logic [7:0] exp);
    wr(FSG_REG_ADDR, {12'h0, FSG_UNLOCK_ADDR1});
    wr(FSG_REG_DATA, 32'h0090);
    run(FSG_CMD_UNLOCK_WRITE);
    wr(FSG_REG_ADDR, {12'h0, a | FSG_QUERY_LOW});
    run(FSG_CMD_PROT_QUERY);
    rd(FSG_REG_PROT, got);
    chk("protection", {24'h0, exp}, got);
    wr(FSG_REG_DATA, 32'h00F0);
    run(FSG_CMD_WRITE);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    rd(FSG_REG_CTRL, got);
    chk("ctrl reset", {24'h0, FSG_CTRL_RESET}, got);
    rd(FSG_REG_STAT, got);
    chk("stat reset", 32'h4, got);
    rd(4'hF, got);
    chk("unmapped", 32'h0, got);
    chk("guard pin", 32'h1, {31'h0, boot_guard_accel_pin});
    prog(20'h12345, 16'h1234);
    fetch(20'h12345, 16'h1234, "unlocked program");
    wr(FSG_REG_ADDR, 32'h22222);
    wr(FSG_REG_DATA, 32'h0);
    run(FSG_CMD_WRITE);
    fetch(20'h22222, 16'hFFFF, "bare write");
    mdl.prot_ff[3] = 1'b1;
    query(20'h40000, FSG_PROT_YES);
    query(20'h12000, FSG_PROT_NO);
    prog(20'h40000, 16'h0);
    fetch(20'h40000, 16'hFFFF, "protected group");
    wr(FSG_REG_CTRL, 32'h5);
    prog(20'h40000, 16'h00FF);
    fetch(20'h40000, 16'h00FF, "temporary unprotect");
    wr(FSG_REG_CTRL, 32'h1);
    prog(20'h40001, 16'h0);
    fetch(20'h40001, 16'hFFFF, "reprotected");
    wr(FSG_REG_CTRL, 32'h0);
    prog(20'hFF000, 16'h0);
    fetch(20'hFF000, 16'hFFFF, "guarded top sector");
    prog(20'hFD000, 16'h1111);
    fetch(20'hFD000, 16'h1111, "inner boot sector");
    wr(FSG_REG_CTRL, 32'h4);
    prog(20'hFF002, 16'h0);
    fetch(20'hFF002, 16'hFFFF, "guard in temporary unprotect");
    mdl.prot_ff[16] = 1'b1;
    wr(FSG_REG_CTRL, 32'h3);
    prog(20'hFF004, 16'h5555);
    fetch(20'hFF004, 16'h5555, "accelerate level");
    wr(FSG_REG_CTRL, 32'h1);
    prog(20'hFF006, 16'h0);
    fetch(20'hFF006, 16'hFFFF, "stored top protection");
    wr(FSG_REG_CTRL, 32'h11);
    @(negedge clk_sys);
    chk("a9 level in system", 32'h0, {31'h0, address_bit_nine_id_high_voltage});
    rd(FSG_REG_CTRL, got);
    chk("ctrl a9 masked", 32'h11 & ~32'h10, got);
    wr(FSG_REG_CTRL, 32'h31);
    rd(FSG_REG_CTRL, got);
    chk("ctrl readback", 32'h31, got);
    chk("a9 level programmer", 32'h1, {31'h0, address_bit_nine_id_high_voltage});
    wr(FSG_REG_CTRL, 32'h1);
    supply_ok <= 1'b0;
    repeat (5) @(posedge clk_sys);
    wr(FSG_REG_ADDR, 32'h33333);
    run(FSG_CMD_WRITE);
    rd(FSG_REG_STAT, got);
    chk("lockout status", 32'h2, got);
    supply_ok <= 1'b1;
    repeat (5) @(posedge clk_sys);
    fetch(20'h33333, 16'hFFFF, "lockout write");
    report_and_stop;
  end
endmodule
